// ---- verilog/msad_decode.v ----
// Program and data space address decode, data RAM, working registers and AGUs.
// Assumes every request input comes from core logic on mclk; program memory and
// the special register blocks answer combinationally outside this module.
`timescale 1ns/10ps
`include "msad_consts.vh"

module msad_decode (
    input wire mclk,
    input wire nrst,
    input wire pc_step,
    input wire pc_down,
    input wire pc_load,
    input wire [22:0] pc_load_value,
    input wire table_read_op,
    input wire table_write_op,
    input wire [7:0] table_page_pointer,
    input wire [15:0] table_offset,
    input wire [7:0] psv_page,
    input wire [23:0] prog_rdata,
    output wire [23:0] prog_addr,
    output wire prog_cfg_access,
    output wire prog_in_vectors,
    output wire prog_in_alt_ivt,
    output wire [22:0] program_counter,
    output reg [15:0] prog_word,
    input wire xr_req,
    input wire xr_byte,
    input wire [1:0] xr_mode,
    input wire [15:0] xr_ptr,
    input wire [12:0] xr_near,
    input wire [15:0] xr_abs,
    input wire xr_post,
    input wire xr_down,
    output reg xr_valid,
    output reg [15:0] xr_data,
    output reg [15:0] xr_ptr_next,
    input wire yr_req,
    input wire [15:0] yr_ptr,
    input wire yr_post,
    input wire yr_down,
    output reg yr_valid,
    output reg [15:0] yr_data,
    output reg [15:0] yr_ptr_next,
    input wire xw_req,
    input wire xw_byte,
    input wire [1:0] xw_mode,
    input wire [15:0] xw_ptr,
    input wire [12:0] xw_near,
    input wire [15:0] xw_abs,
    input wire xw_post,
    input wire xw_down,
    input wire xw_bitrev,
    input wire [15:0] xw_data,
    output reg [15:0] xw_ptr_next,
    input wire x_mod_en,
    input wire [15:0] x_mod_start,
    input wire [15:0] x_mod_end,
    input wire y_mod_en,
    input wire [15:0] y_mod_start,
    input wire [15:0] y_mod_end,
    input wire [14:0] bitrev_modifier,
    input wire sfr_hit,
    input wire [15:0] sfr_rdata,
    output wire [15:0] sfr_addr,
    output wire sfr_we_lo,
    output wire sfr_we_hi,
    output wire [15:0] sfr_wdata,
    input wire wreg_we,
    input wire wreg_byte,
    input wire [3:0] wreg_widx,
    input wire [15:0] wreg_wdata,
    input wire [3:0] wreg_ridx,
    output reg [15:0] wreg_rdata,
    output reg addr_error_trap
);

    reg [22:0] pc;
    reg [15:0] ram [0:`MSAD_RAM_WORDS-1];
    reg [15:0] wreg [0:15];
    reg [15:0] x_word;
    reg [15:0] y_word;
    reg [15:0] next_xr_ptr;
    reg [15:0] next_yr_ptr;
    reg [15:0] next_xw_ptr;
    wire [15:0] xr_ea;
    wire [15:0] xw_ea;
    wire xr_psv;
    wire [13:0] xr_idx;
    wire [13:0] yr_idx;
    wire [13:0] xw_idx;
    wire xr_in_ram;
    wire yr_in_y;
    wire xw_in_ram;
    wire xr_in_sfr;
    wire xw_in_sfr;
    wire xr_misalign;
    wire xw_misalign;
    wire xw_lo;
    wire xw_hi;

    // Forms an effective address from the selected source.
    function [15:0] form_ea;
        input [1:0] mode;
        input [15:0] ptr;
        input [12:0] near;
        input [15:0] abs16;
        begin
            case (mode)
                `MSAD_MODE_DIR13: form_ea = {3'h0, near};
                `MSAD_MODE_DIR16: form_ea = abs16;
                default: form_ea = ptr;
            endcase
        end
    endfunction

    // Linear or modulo post-modify of a pointer.
    function [15:0] agu_step;
        input [15:0] ptr;
        input down;
        input byte_op;
        input men;
        input [15:0] ms;
        input [15:0] me;
        reg [15:0] step;
        reg [15:0] raw;
        begin
            step = byte_op ? `MSAD_BYTE_STEP : `MSAD_WORD_STEP;
            raw = down ? ptr - step : ptr + step;
            agu_step = raw;
            if (men && !down && ptr <= me && raw > me) begin
                agu_step = ms;
            end else if (men && down && ptr >= ms && raw < ms) begin
                agu_step = me - step + `MSAD_BYTE_STEP;
            end
        end
    endfunction

    // Reverses the 15 word-address bits so a carry ripples from the top.
    function [14:0] rev15;
        input [14:0] v;
        integer i;
        begin
            rev15 = 15'h0000;
            for (i = 0; i < 15; i = i + 1) begin
                rev15[i] = v[14 - i];
            end
        end
    endfunction

    // Program side.
    assign program_counter = pc;
    // Table operations win over the data window, and the window over fetch.
    assign prog_addr = (table_read_op || table_write_op) ?
        {table_page_pointer, table_offset} :
        (xr_req && xr_psv) ? {1'b0, psv_page, xr_ea[14:0]} : {1'b0, pc};
    assign prog_cfg_access = (table_read_op || table_write_op) &&
        table_page_pointer[`MSAD_CFG_PAGE_BIT];
    assign prog_in_vectors = prog_addr < `MSAD_VEC_TOP;
    assign prog_in_alt_ivt = prog_addr >= `MSAD_AIVT_START &&
        prog_addr <= `MSAD_AIVT_END;

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pc <= `MSAD_PC_RESET;
        end else if (pc_load) begin
            // Load wins over step, so a jump never lands one word off its target.
            pc <= {pc_load_value[22:1], 1'b0};
        end else if (pc_step) begin
            pc <= pc_down ? pc - `MSAD_PC_STEP : pc + `MSAD_PC_STEP;
        end
    end

    // Table reads pick a word by address parity; the unused top byte reads zero.
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prog_word <= 16'h0000;
        end else if (table_offset[0] && (table_read_op || table_write_op)) begin
            prog_word <= {8'h00, prog_rdata[23:16]};
        end else begin
            prog_word <= prog_rdata[15:0];
        end
    end

    // Data address decode.
    assign xr_ea = form_ea(xr_mode, xr_ptr, xr_near, xr_abs);
    assign xw_ea = form_ea(xw_mode, xw_ptr, xw_near, xw_abs);
    assign xr_psv = xr_ea[`MSAD_PSV_BIT];
    assign xr_in_ram = !xr_psv && xr_ea >= `MSAD_RAM_BASE;
    assign yr_in_y = yr_ptr >= `MSAD_Y_BASE && yr_ptr <= `MSAD_RAM_END;
    assign xw_in_ram = !xw_ea[`MSAD_PSV_BIT] && xw_ea >= `MSAD_RAM_BASE;
    assign xr_in_sfr = !xr_psv && xr_ea <= `MSAD_SFR_END;
    assign xw_in_sfr = xw_ea <= `MSAD_SFR_END;
    assign xr_idx = xr_ea[14:1] - `MSAD_RAM_BASE_IDX;
    assign yr_idx = yr_ptr[14:1] - `MSAD_RAM_BASE_IDX;
    assign xw_idx = xw_ea[14:1] - `MSAD_RAM_BASE_IDX;
    assign xr_misalign = xr_req && !xr_byte && xr_ea[0];
    assign xw_misalign = xw_req && !xw_byte && xw_ea[0];

    // Byte lanes share one word decode; each lane has its own strobe.
    // A misaligned word write loses its strobes, yet its pointer still moves.
    assign xw_lo = xw_req && !xw_misalign && (!xw_byte || !xw_ea[0]);
    assign xw_hi = xw_req && !xw_misalign && (!xw_byte || xw_ea[0]);
    // One register port serves both buses and a write takes its address, so the
    // core must not read and write registers in the same cycle.
    assign sfr_addr = xw_req ? {xw_ea[15:1], 1'b0} : {xr_ea[15:1], 1'b0};
    assign sfr_we_lo = xw_lo && xw_in_sfr;
    assign sfr_we_hi = xw_hi && xw_in_sfr;
    assign sfr_wdata = xw_byte ? {xw_data[7:0], xw_data[7:0]} : xw_data;

    // Every word source of the unified X read path.
    always @* begin
        x_word = 16'h0000;
        if (xr_psv) begin
            x_word = prog_rdata[15:0];
        end else if (xr_in_ram) begin
            x_word = ram[xr_idx];
        end else if (xr_in_sfr && sfr_hit) begin
            x_word = sfr_rdata;
        end
    end

    // The Y path decodes on its own so a dual fetch never waits on the X path.
    always @* begin
        y_word = 16'h0000;
        if (yr_in_y) begin
            y_word = ram[yr_idx];
        end
    end

    // Pointer updates; bit-reversed stepping exists only on the write side.
    always @* begin
        next_xr_ptr = agu_step(xr_ptr, xr_down, xr_byte, x_mod_en,
            x_mod_start, x_mod_end);
        next_yr_ptr = agu_step(yr_ptr, yr_down, 1'b0, y_mod_en,
            y_mod_start, y_mod_end);
        if (xw_bitrev) begin
            next_xw_ptr = {rev15(rev15(xw_ptr[15:1]) + rev15(bitrev_modifier)),
                xw_ptr[0]};
        end else begin
            next_xw_ptr = agu_step(xw_ptr, xw_down, xw_byte, x_mod_en,
                x_mod_start, x_mod_end);
        end
    end

    // Read buses run in the same cycle so a dual-operand fetch takes one edge.
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            xr_valid <= 1'b0;
            xr_data <= 16'h0000;
            xr_ptr_next <= 16'h0000;
            yr_valid <= 1'b0;
            yr_data <= 16'h0000;
            yr_ptr_next <= 16'h0000;
            xw_ptr_next <= 16'h0000;
            addr_error_trap <= 1'b0;
        end else begin
            xr_valid <= xr_req;
            yr_valid <= yr_req;
            if (xr_req) begin
                if (xr_byte) begin
                    xr_data <= {8'h00, xr_ea[0] ? x_word[15:8] : x_word[7:0]};
                end else begin
                    xr_data <= x_word;
                end
                xr_ptr_next <= (xr_post && xr_mode == `MSAD_MODE_IND) ?
                    next_xr_ptr : xr_ptr;
            end
            if (yr_req) begin
                yr_data <= y_word;
                yr_ptr_next <= yr_post ? next_yr_ptr : yr_ptr;
            end
            if (xw_req) begin
                xw_ptr_next <= (xw_post && xw_mode == `MSAD_MODE_IND) ?
                    next_xw_ptr : xw_ptr;
            end
            // Registered so the trap lines up with the answer of the offending access.
            addr_error_trap <= xr_misalign || xw_misalign;
        end
    end

    // Data RAM holds no reset; writes land through the unified X write bus.
    // Clearing it would take a cycle per word, so software initialises it before use.
    always @(posedge mclk) begin
        if (xw_in_ram && xw_lo) begin
            ram[xw_idx][7:0] <= xw_data[7:0];
        end
        if (xw_in_ram && xw_hi) begin
            ram[xw_idx][15:8] <= xw_byte ? xw_data[7:0] : xw_data[15:8];
        end
    end

    // Working registers; a byte load leaves the high byte alone.
    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : wr_gen
            always @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    wreg[g] <= (g == 15) ? `MSAD_WREG15_RESET : `MSAD_WREG_RESET;
                end else if (wreg_we && wreg_widx == g) begin
                    if (wreg_byte) begin
                        wreg[g][7:0] <= wreg_wdata[7:0];
                    end else begin
                        wreg[g] <= wreg_wdata;
                    end
                end
            end
        end
    endgenerate

    // The read port is registered, so a write shows on it one cycle later.
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wreg_rdata <= 16'h0000;
        end else begin
            wreg_rdata <= wreg[wreg_ridx];
        end
    end

endmodule

// ---- verilog/msad_consts.vh ----
// Constants for the memory space address decode block.
// Assumes inclusion by the decode module only; holds definitions and nothing else.
`ifndef MSAD_CONSTS_VH
`define MSAD_CONSTS_VH

// Program space.
`define MSAD_PADDR_W 24
`define MSAD_PC_W 23
`define MSAD_PC_RESET 23'h000000
`define MSAD_PC_STEP 23'h000002
`define MSAD_USER_TOP 24'h7FFFFF
`define MSAD_CFG_PAGE_BIT 7
`define MSAD_VEC_TOP 24'h000200
`define MSAD_IVT_START 24'h000004
`define MSAD_AIVT_START 24'h000100
`define MSAD_AIVT_END 24'h0001FF
`define MSAD_START_VEC 24'h000002

// Data space.
`define MSAD_EA_W 16
`define MSAD_PSV_BIT 15
`define MSAD_SFR_END 16'h07FF
`define MSAD_NEAR_END 16'h1FFF
`define MSAD_RAM_BASE 16'h0800
`define MSAD_RAM_BASE_IDX 14'h0400
`define MSAD_RAM_WORDS 15360
`define MSAD_RAM_END 16'h7FFF
`define MSAD_Y_BASE 16'h4800
`define MSAD_BYTE_STEP 16'h0001
`define MSAD_WORD_STEP 16'h0002

// Working registers.
`define MSAD_WREG_RESET 16'h0000
`define MSAD_WREG15_RESET 16'h0800

// Address source modes.
`define MSAD_MODE_IND 2'h0
`define MSAD_MODE_DIR13 2'h1
`define MSAD_MODE_DIR16 2'h2

`endif

// ---- dv/msad_checker.sv ----
// Concurrent checks on the decode block's ports.
// Assumes binding into every msad_decode instance; one clock, reset active low.
`timescale 1ns/10ps
module msad_checker (
    input logic mclk,
    input logic nrst,
    input logic pc_step,
    input logic pc_down,
    input logic pc_load,
    input logic [22:0] program_counter,
    input logic [23:0] prog_addr,
    input logic prog_in_vectors,
    input logic xr_req,
    input logic xr_byte,
    input logic [1:0] xr_mode,
    input logic [15:0] xr_ptr,
    input logic xr_valid,
    input logic xw_req,
    input logic xw_byte,
    input logic [1:0] xw_mode,
    input logic [15:0] xw_ptr,
    input logic sfr_we_lo,
    input logic sfr_we_hi,
    input logic addr_error_trap
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    rd_answer_a: assert property (xr_req |=> xr_valid) else $error("read not answered");
    rd_quiet_a: assert property (!xr_req |=> !xr_valid) else $error("spurious valid");
    pc_even_a: assert property (program_counter[0] == 1'b0) else $error("odd counter");
    pc_step_a: assert property (pc_step && !pc_load |=> program_counter == ($past(pc_down) ?
        $past(program_counter) - 23'h000002 : $past(program_counter) + 23'h000002))
        else $error("counter step wrong");
    rd_trap_a: assert property (xr_req && !xr_byte && xr_mode == 2'h0 && xr_ptr[0]
        |=> addr_error_trap) else $error("no trap on odd read");
    trap_cause_a: assert property (addr_error_trap |-> $past(xr_req) && !$past(xr_byte)
        || $past(xw_req) && !$past(xw_byte)) else $error("trap without cause");
    wr_supp_a: assert property (xw_req && !xw_byte && xw_mode == 2'h0 && xw_ptr[0]
        |-> !sfr_we_lo && !sfr_we_hi) else $error("odd word write strobed");
    byte_lane_a: assert property (xw_req && xw_byte && xw_mode == 2'h0 && xw_ptr <= 16'h07FF
        |-> sfr_we_lo != xw_ptr[0] && sfr_we_hi == xw_ptr[0]) else $error("lane wrong");
    vec_flag_a: assert property (prog_in_vectors == (prog_addr < 24'h000200))
        else $error("vector flag wrong");
endmodule
bind msad_decode msad_checker chk_u (.*);

// ---- dv/msad_prog_sfr_model.sv ----
// Program memory and one special register answering the decode block.
// Assumes the block's program and register ports; answers in the same cycle.
`timescale 1ns/10ps
module msad_prog_sfr_model (
    input wire logic mclk,
    input wire logic [23:0] prog_addr,
    output logic [23:0] prog_rdata,
    input wire logic [15:0] sfr_addr,
    input wire logic sfr_we_lo,
    input wire logic sfr_we_hi,
    input wire logic [15:0] sfr_wdata,
    output logic sfr_hit,
    output logic [15:0] sfr_rdata
);
    logic [15:0] scratch = 16'h0000;
    // Upper byte differs from the low word so a lane swap cannot pass.
    assign prog_rdata = {prog_addr[7:0], prog_addr[15:0] ^ 16'hA5C3};
    assign sfr_hit = (sfr_addr == 16'h0020);
    // A miss shows a changing pattern, so ignoring the hit flag is caught.
    assign sfr_rdata = sfr_hit ? scratch : ~scratch ^ sfr_addr;
    always @(posedge mclk) begin
        if (sfr_hit && sfr_we_lo)
            scratch[7:0] <= sfr_wdata[7:0];
        if (sfr_hit && sfr_we_hi)
            scratch[15:8] <= sfr_wdata[15:8];
    end
endmodule

// ---- dv/msad_decode_tb.sv ----
// Self-checking bench for the memory space address decode block.
// Assumes the program and register model stands on the far side.
`timescale 1ns/10ps
module msad_decode_tb;
    logic mclk = 0, nrst = 0, pc_step = 0, pc_down = 0, pc_load = 0, table_read_op = 0;
    logic table_write_op = 0, xr_req = 0, xr_byte = 0, xr_post = 1, xr_down = 0, yr_req = 0;
    logic yr_post = 0, yr_down = 0, xw_req = 0, xw_byte = 0, xw_post = 1, xw_down = 0;
    logic xw_bitrev = 0, x_mod_en = 0, y_mod_en = 0, wreg_we = 0, wreg_byte = 0;
    logic [1:0] xr_mode = 0, xw_mode = 0;
    logic [3:0] wreg_widx = 0, wreg_ridx = 4'hF;
    logic [7:0] table_page_pointer = 0, psv_page = 0;
    logic [12:0] xr_near = 0, xw_near = 0;
    logic [14:0] bitrev_modifier = 0;
    logic [15:0] table_offset = 0, xr_ptr = 0, xr_abs = 0, yr_ptr = 0, xw_ptr = 0, xw_abs = 0;
    logic [15:0] xw_data = 0, x_mod_start = 0, x_mod_end = 0, y_mod_start = 0, y_mod_end = 0;
    logic [15:0] wreg_wdata = 0;
    logic [22:0] pc_load_value = 0;
    wire [22:0] program_counter;
    wire [23:0] prog_rdata, prog_addr;
    wire [15:0] prog_word, xr_data, xr_ptr_next, yr_data, yr_ptr_next, xw_ptr_next, sfr_rdata;
    wire [15:0] sfr_addr, sfr_wdata, wreg_rdata;
    wire prog_cfg_access, prog_in_vectors, prog_in_alt_ivt, xr_valid, yr_valid, sfr_hit;
    wire sfr_we_lo, sfr_we_hi, addr_error_trap;
    int fails = 0, num_checks = 0, cycles = 0;
    msad_decode dut_u (.*);
    msad_prog_sfr_model mdl_u (.*);
    always #50 mclk = ~mclk;
    task cyc;
        @(posedge mclk);
        #1;
    endtask
    task chk(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task rd(input logic [1:0] m, input logic [15:0] ea, input logic b);
        xr_mode = m;
        xr_ptr = ea;
        xr_abs = ea;
        xr_near = ea[12:0];
        xr_byte = b;
        xr_req = 1;
        cyc;
        chk(xr_valid, 1'b1);
    endtask
    task wr(input logic [15:0] ea, input logic b, input logic [15:0] d);
        xw_ptr = ea;
        xw_byte = b;
        xw_data = d;
        xw_req = 1;
        cyc;
    endtask
    task idle;
        xr_req = 0;
        xw_req = 0;
        yr_req = 0;
        cyc;
    endtask
    task t_pc;
        chk(prog_addr, 24'h000000);
        pc_step = 1;
        cyc;
        cyc;
        chk(program_counter, 23'h000004);
        pc_down = 1;
        cyc;
        chk(program_counter, 23'h000002);
        pc_step = 0;
        pc_load = 1;
        pc_load_value = 23'h000101;
        cyc;
        chk(prog_in_alt_ivt, 1'b1);
        chk(prog_in_vectors, 1'b1);
        pc_load_value = 23'h000200;
        cyc;
        chk(prog_in_vectors, 1'b0);
        pc_load = 0;
    endtask
    task t_ram;
        wr(16'h0800, 0, 16'h1234);
        wr(16'h0801, 1, 16'h00AB);
        chk(xw_ptr_next, 16'h0802);
        rd(0, 16'h0800, 0);
        chk(xr_data, 16'hAB34);
        rd(0, 16'h0801, 1);
        chk(xr_data, 16'h00AB);
        chk(xr_ptr_next, 16'h0802);
        wr(16'h0802, 0, 16'h5A5A);
        wr(16'h0803, 0, 16'hFFFF);
        chk(addr_error_trap, 1'b1);
        idle;
        rd(0, 16'h0803, 0);
        chk(xr_data, 16'h5A5A);
        chk(addr_error_trap, 1'b1);
    endtask
    task t_space;
        idle;
        rd(0, 16'h0100, 0);
        chk(xr_data, 16'h0000);
        idle;
        wr(16'h0021, 1, 16'h00C3);
        wr(16'h0020, 1, 16'h0096);
        idle;
        rd(0, 16'h0020, 0);
        chk(xr_data, 16'hC396);
        psv_page = 8'h03;
        rd(2, 16'h8004, 0);
        chk(xr_data, 16'h8004 ^ 16'hA5C3);
        chk(prog_addr, 24'h018004);
        rd(1, 16'h0802, 0);
        chk(xr_data, 16'h5A5A);
        x_mod_en = 1;
        x_mod_start = 16'h0800;
        x_mod_end = 16'h0807;
        rd(0, 16'h0806, 0);
        chk(xr_ptr_next, 16'h0800);
        xr_down = 1;
        rd(0, 16'h0800, 0);
        chk(xr_ptr_next, 16'h0806);
        xr_down = 0;
        x_mod_en = 0;
        wr(16'h4800, 0, 16'h7E81);
        idle;
        yr_ptr = 16'h4800;
        yr_post = 1;
        yr_req = 1;
        rd(0, 16'h0800, 0);
        chk(yr_data, 16'h7E81);
        chk(yr_valid, 1'b1);
        chk(yr_ptr_next, 16'h4802);
        chk(xr_data, 16'hAB34);
        y_mod_en = 1;
        y_mod_start = 16'h0800;
        y_mod_end = 16'h0803;
        yr_ptr = 16'h0802;
        cyc;
        chk(yr_data, 16'h0000);
        chk(yr_ptr_next, 16'h0800);
        idle;
        chk(yr_valid, 1'b0);
        xw_bitrev = 1;
        bitrev_modifier = 15'h0004;
        wr(16'h0800, 0, 16'hAB34);
        chk(xw_ptr_next, 16'h0808);
        idle;
    endtask
    task t_misc;
        chk(wreg_rdata, 16'h0800);
        wreg_we = 1;
        wreg_widx = 4'h3;
        wreg_wdata = 16'h1234;
        cyc;
        wreg_byte = 1;
        wreg_wdata = 16'hBE56;
        cyc;
        wreg_we = 0;
        wreg_ridx = 4'h3;
        cyc;
        chk(wreg_rdata, 16'h1256);
        table_read_op = 1;
        table_page_pointer = 8'h80;
        table_offset = 16'h0011;
        cyc;
        chk(prog_addr, 24'h800011);
        chk(prog_cfg_access, 1'b1);
        chk(prog_word, 16'h0011);
        table_page_pointer = 8'h01;
        table_offset = 16'h0010;
        cyc;
        chk(prog_cfg_access, 1'b0);
        chk(prog_word, 16'hA5D3);
        table_read_op = 0;
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            finish_test;
        end
    end
    initial begin
        repeat (8) @(posedge mclk);
        #1 nrst = 1;
        t_pc;
        t_ram;
        t_space;
        t_misc;
        finish_test;
    end
endmodule
